// File: cspbs_board_model.sv
// Purpose: Board side model: straps, boot flash and far link end
// Assumes: Straps are set by the bench while reset is held
// Notes: Flash repeats one data byte after the 32 command bits
`timescale 1ns/100ps
`default_nettype none
module cspbs_board_model #(
  parameter logic [7:0] FLASH_BYTE = 8'hA5
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cfg_osc_n,
  input wire logic [1:0] i_cfg_ratio,
  input wire logic [2:0] i_cfg_boot,
  input wire logic i_link_talk,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  output logic o_osc_ext_n,
  output logic o_ratio_lo,
  output logic o_ratio_hi,
  output logic [2:0] o_boot,
  output logic o_spi_miso,
  output logic o_link_in_a,
  output logic o_link_in_b
);
  int falls = 0;

  // ---------------------------------------------------------------
  // Straps load only in reset and then stay put
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {o_osc_ext_n, o_ratio_hi, o_ratio_lo, o_boot} <= {i_cfg_osc_n, i_cfg_ratio, i_cfg_boot};
    end
  end

  // ---------------------------------------------------------------
  // Flash shifts on falling sclk, pull-up when not driving
  // ---------------------------------------------------------------
  always @(negedge i_spi_sclk or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      falls <= 0;
    end else begin
      falls <= falls + 1;
    end
  end
  assign o_spi_miso = (!i_spi_cs_n && falls >= 32) ? FLASH_BYTE[3'(7 - (falls - 32) % 8)] : 1'b1;

  // Link inputs low until the bench asks for traffic
  assign o_link_in_a = i_link_talk;
  assign o_link_in_b = i_link_talk;
endmodule // cspbs_board_model
`default_nettype wire

// File: cspbs_boot_ctrl.sv
// Purpose: Clock source select, PLL set-up and reset-to-boot strap sequencing
// Assumes: Straps and link inputs are asynchronous board pins
// Notes: Clock figures are reported in kHz for software
`timescale 1ns/100ps
`default_nettype none

module cspbs_boot_ctrl
  import cspbs_pkg::*;
#(
  parameter int GPIO_W = 16,
  parameter int EXT_OSC_KHZ = 24000,
  parameter int RESET_DELAY = RESET_DELAY_CLKS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_osc_ext_n,
  input wire logic i_pll_ratio_strap_lo,
  input wire logic i_pll_ratio_strap_hi,
  input wire logic [2:0] i_boot_src_strap,
  input wire logic [7:0] i_security_reg,
  input wire logic i_boot_link_in_a,
  input wire logic i_boot_link_in_b,
  input wire logic i_spi_miso,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic o_osc_sel_ext,
  output logic o_analog_clk_sel_ext,
  output logic o_pll_clk_en,
  output logic [2:0] o_output_divider,
  output logic [11:0] o_pll_mult,
  output logic [5:0] o_ref_divider,
  output logic [15:0] o_ref_clk_div,
  output logic [GPIO_W-1:0] o_gpio_oe_n,
  output logic o_gpio_pull_en,
  output logic o_boot_start,
  output logic [1:0] o_boot_src,
  output logic o_bootrom_bypass,
  output logic [12:0] o_otp_start_addr,
  output logic o_spi_sclk,
  output logic o_spi_cs_n,
  output logic o_spi_mosi,
  output logic o_spi_oe_n,
  output logic [7:0] o_boot_byte,
  output logic o_boot_byte_valid,
  output logic o_link_pd_en,
  output logic o_boot_link_out_a,
  output logic o_boot_link_out_b,
  output logic o_boot_link_oe_n,
  output logic o_link_traffic
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    st_strap, st_hold, st_pick, st_spi, st_link_wait, st_link, st_otp, st_none
  } cspbs_state_e;

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] filt;
    logic [2:0] edges;
    logic osc_ext;
    logic [1:0] ratio;
    logic [2:0] boot_code;
    cspbs_pll_s pll;
    logic [31:0] hold_cnt;
    cspbs_state_e st;
    cspbs_boot_e src;
    logic pend;
    logic calc_wait;
    logic calc_go;
    logic calc_ph;
    logic [31:0] core_khz;
    logic [15:0] ref_div;
    logic pull_en;
    logic boot_start;
    logic [4:0] link_cnt;
    logic link_en;
    logic traffic;
    logic [5:0] half_cnt;
    logic sclk;
    logic [5:0] bits;
    logic [31:0] tx;
    logic [7:0] rx;
    logic [2:0] rx_n;
    logic [7:0] rx_byte;
    logic rx_vld;
    logic [31:0] rdata;
  } cspbs_ctrl_s;

  cspbs_ctrl_s q;
  cspbs_ctrl_s next_q;
  cspbs_div_if dif ();

  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] agree;
  logic [31:0] osc_khz;
  logic [31:0] status_word;

  // ---------------------------------------------------------------
  // Divider for clock figures
  // ---------------------------------------------------------------
  cspbs_divider u_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .div(dif.srv)
  );

  assign pins = {i_spi_miso, i_boot_link_in_b, i_boot_link_in_a, i_boot_src_strap,
                 i_pll_ratio_strap_hi, i_pll_ratio_strap_lo, i_osc_ext_n};
  assign agree = ~(q.s2 ^ q.s3);
  assign osc_khz = q.osc_ext ? 32'(EXT_OSC_KHZ) : 32'(INT_OSC_KHZ);
  assign status_word = {20'h0, q.osc_ext, q.ratio, q.boot_code, q.src,
                        q.pull_en, q.link_en, q.calc_wait | q.pend, q.st != st_strap};

  // Core clock: osc * (F+1) / (2 * (R+1) * (OD+1)); reference: core / 100 MHz
  assign dif.start = q.calc_go;
  assign dif.num = q.calc_ph ? q.core_khz
                             : 32'(osc_khz * ({20'h0, q.pll.f} + 32'h1));
  assign dif.den = q.calc_ph ? 32'(REF_CLK_KHZ)
                             : 32'(2 * ({26'h0, q.pll.r} + 32'h1) * ({29'h0, q.pll.od} + 32'h1));

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.calc_go = 1'b0;
    next_q.rx_vld = 1'b0;
    next_q.boot_start = 1'b0;
    next_q.rdata = 32'h0;

    // Pin synchronisers, value taken once stages two and three agree
    next_q.s1 = pins;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.filt = (agree & q.s3) | (~agree & q.filt);

    // Sequencing
    unique case (q.st)
      st_strap: begin
        next_q.edges = q.edges + 3'h1;
        if (q.edges == 3'(STRAP_EDGE - 1)) begin
          next_q.osc_ext = ~q.s2[IDX_OSC];
          next_q.ratio = {q.s2[IDX_RATIO_HI], q.s2[IDX_RATIO_LO]};
          next_q.boot_code = q.s2[IDX_BOOT +: 3];
          next_q.pll = pll_default({q.s2[IDX_RATIO_HI], q.s2[IDX_RATIO_LO]});
          next_q.pend = 1'b1;
          next_q.st = st_hold;
        end
      end
      st_hold: begin
        next_q.hold_cnt = q.hold_cnt + 32'h1;
        if (q.hold_cnt == 32'(RESET_DELAY - STRAP_EDGE - 1)) begin
          next_q.pull_en = 1'b1;
          next_q.boot_start = 1'b1;
          next_q.st = st_pick;
        end
      end
      st_pick: begin
        if (i_security_reg[SEC_BOOT_BIT]) begin
          next_q.src = boot_otp;
          next_q.st = st_otp;
        end else if (q.boot_code == BOOT_CODE_SPI) begin
          next_q.src = boot_spi;
          next_q.tx = {SPI_READ_CMD, 24'h0};
          next_q.st = st_spi;
        end else if (q.boot_code == BOOT_CODE_LINK) begin
          next_q.src = boot_link;
          next_q.link_cnt = 5'h1;
          next_q.st = st_link_wait;
        end else begin
          next_q.src = boot_none;
          next_q.st = st_none;
        end
      end
      st_spi: begin
        next_q.half_cnt = q.half_cnt + 6'h01;
        if (q.half_cnt == 6'(SPI_HALF_CYC - 1)) begin
          next_q.half_cnt = 6'h00;
          next_q.sclk = ~q.sclk;
          if (!q.sclk) begin
            if (q.bits != 6'd32) begin
              next_q.bits = q.bits + 6'h01;
            end else begin
              next_q.rx = {q.rx[6:0], q.filt[IDX_MISO]};
              next_q.rx_n = q.rx_n + 3'h1;
              if (q.rx_n == 3'h7) begin
                next_q.rx_byte = {q.rx[6:0], q.filt[IDX_MISO]};
                next_q.rx_vld = 1'b1;
              end
            end
          end else begin
            next_q.tx = {q.tx[30:0], 1'b0};
          end
        end
      end
      st_link_wait: begin
        next_q.link_cnt = q.link_cnt + 5'h01;
        if (q.link_cnt == 5'(LINK_EN_CYC - 1)) begin
          next_q.link_en = 1'b1;
          next_q.st = st_link;
        end
      end
      st_link: begin
        next_q.traffic = q.filt[IDX_LINK_A] | q.filt[IDX_LINK_B];
      end
      st_otp: begin
        next_q.st = st_otp;
      end
      st_none: begin
        next_q.st = st_none;
      end
    endcase

    // Clock figure calculation
    if (q.pend && !dif.busy && !q.calc_wait) begin
      next_q.pend = 1'b0;
      next_q.calc_go = 1'b1;
      next_q.calc_wait = 1'b1;
      next_q.calc_ph = 1'b0;
    end
    if (q.calc_wait && dif.done) begin
      if (!q.calc_ph) begin
        next_q.core_khz = dif.quo;
        next_q.calc_ph = 1'b1;
        next_q.calc_go = 1'b1;
      end else begin
        next_q.ref_div = (dif.quo[15:0] == 16'h0) ? 16'h1 : dif.quo[15:0];
        next_q.calc_wait = 1'b0;
        next_q.calc_ph = 1'b0;
      end
    end

    // Register writes
    if (i_reg_wr && i_reg_addr == ADDR_PLL_CFG) begin
      next_q.pll.f = i_reg_wdata[F_LSB +: 12];
      next_q.pll.r = i_reg_wdata[R_LSB +: 6];
      next_q.pll.od = i_reg_wdata[OD_LSB +: 3];
      next_q.pend = 1'b1;
    end

    // Register reads, data in the following cycle only
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_PLL_CFG: next_q.rdata = {9'h0, q.pll.od, 2'h0, q.pll.r, q.pll.f};
        ADDR_STATUS: next_q.rdata = status_word;
        ADDR_CORE_KHZ: next_q.rdata = q.core_khz;
        ADDR_REF_DIV: next_q.rdata = {16'h0, q.ref_div};
        default: next_q.rdata = 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_reg_rdata = q.rdata;
  assign o_osc_sel_ext = q.osc_ext;
  assign o_analog_clk_sel_ext = q.osc_ext;
  assign o_pll_clk_en = q.st != st_strap;
  assign o_output_divider = q.pll.od;
  assign o_pll_mult = q.pll.f;
  assign o_ref_divider = q.pll.r;
  assign o_ref_clk_div = q.ref_div;
  assign o_gpio_oe_n = '1;
  assign o_gpio_pull_en = q.pull_en;
  assign o_boot_start = q.boot_start;
  assign o_boot_src = q.src;
  assign o_bootrom_bypass = q.src == boot_otp;
  assign o_otp_start_addr = 13'h0000;
  assign o_spi_sclk = q.sclk;
  assign o_spi_cs_n = q.st != st_spi;
  assign o_spi_mosi = q.tx[31];
  assign o_spi_oe_n = q.st != st_spi;
  assign o_boot_byte = q.rx_byte;
  assign o_boot_byte_valid = q.rx_vld;
  assign o_link_pd_en = ~q.link_en;
  assign o_boot_link_out_a = 1'b0;
  assign o_boot_link_out_b = 1'b0;
  assign o_boot_link_oe_n = ~q.link_en;
  assign o_link_traffic = q.traffic;

endmodule // cspbs_boot_ctrl
`default_nettype wire

// File: cspbs_boot_ctrl_asserts.sv
// Purpose: Port assertions for the boot control block
// Assumes: One clock, asynchronous active-high reset
// Notes: Attached by bind at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module cspbs_boot_ctrl_asserts
  import cspbs_pkg::*;
#(
  parameter int GPIO_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic o_osc_sel_ext,
  input wire logic o_analog_clk_sel_ext,
  input wire logic o_pll_clk_en,
  input wire logic [GPIO_W-1:0] o_gpio_oe_n,
  input wire logic o_gpio_pull_en,
  input wire logic o_boot_start,
  input wire logic [1:0] o_boot_src,
  input wire logic o_bootrom_bypass,
  input wire logic [12:0] o_otp_start_addr,
  input wire logic o_spi_sclk,
  input wire logic o_spi_cs_n,
  input wire logic o_link_pd_en,
  input wire logic o_boot_link_out_a,
  input wire logic o_boot_link_out_b,
  input wire logic o_boot_link_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] gap;
  logic seen;

  // ---------------------------------------------------------------
  // Cycles since last sclk change within a frame
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gap <= 8'h00;
      seen <= 1'b0;
    end else begin
      gap <= $changed(o_spi_sclk) ? 8'h00 : gap + 8'h01;
      seen <= !o_spi_cs_n && (seen || $changed(o_spi_sclk));
    end
  end

  sequence s_link_pick;
    o_boot_start ##1 o_boot_src == 2'h2;
  endsequence
  sequence s_link_up;
    ##[5:40] $fell(o_boot_link_oe_n);
  endsequence

  chk_pins_released: assert property (&o_gpio_oe_n)
    else $error("gpio driven");
  chk_analog_osc: assert property (o_analog_clk_sel_ext == o_osc_sel_ext)
    else $error("analog clock differs from osc");
  chk_tile_clock: assert property (o_boot_start |-> o_pll_clk_en && o_gpio_pull_en)
    else $error("boot without pll clock or pulls");
  chk_pull_start: assert property ($rose(o_gpio_pull_en) |-> o_boot_start)
    else $error("pulls without boot start");
  chk_pull_hold: assert property (o_gpio_pull_en |=> o_gpio_pull_en)
    else $error("pulls dropped");
  chk_src_hold: assert property (o_gpio_pull_en && !$past(o_boot_start) |-> $stable(o_boot_src))
    else $error("boot source moved");
  chk_otp_bypass: assert property (o_bootrom_bypass == (o_boot_src == 2'h3) && o_otp_start_addr == 13'h0)
    else $error("secure boot bypass wrong");
  chk_sclk_half: assert property ($changed(o_spi_sclk) && seen |-> gap == 8'(SPI_HALF_CYC - 1))
    else $error("sclk half period wrong");
  chk_link_delay: assert property (s_link_pick |-> s_link_up)
    else $error("link enable late");
  chk_link_idle: assert property (!o_boot_link_oe_n |-> !o_link_pd_en && !o_boot_link_out_a && !o_boot_link_out_b)
    else $error("link idle state wrong");
  chk_read_quiet: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule // cspbs_boot_ctrl_asserts

bind cspbs_boot_ctrl cspbs_boot_ctrl_asserts #(.GPIO_W(GPIO_W)) u_chk (.i_clk, .i_rst, .i_reg_rd,
  .o_reg_rdata, .o_osc_sel_ext, .o_analog_clk_sel_ext, .o_pll_clk_en, .o_gpio_oe_n,
  .o_gpio_pull_en, .o_boot_start, .o_boot_src, .o_bootrom_bypass, .o_otp_start_addr, .o_spi_sclk,
  .o_spi_cs_n, .o_link_pd_en, .o_boot_link_out_a, .o_boot_link_out_b, .o_boot_link_oe_n);
`default_nettype wire

// File: cspbs_boot_ctrl_test.sv
// Purpose: Self-checking bench for the boot control block
// Assumes: Short reset delay parameter for simulation
// Notes: Each scenario reboots the block with its own straps
`timescale 1ns/100ps
`default_nettype none
module cspbs_boot_ctrl_test;
  import cspbs_pkg::*;
  localparam int RD = 50;
  localparam int EXT_KHZ = 24000;
  localparam logic [7:0] FB = 8'hA5;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic talk = 1'b0;
  logic cosc = 1'b1;
  logic [1:0] cratio = 2'h0;
  logic [2:0] cboot = 3'h0;
  logic [7:0] sec = 8'h00;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic osc_n, rlo, rhi, miso, la, lb, sel_ext, pll_en, pull_en, bstart, bypass, sclk, cs_n;
  logic spi_oe_n, bvalid, pd_en, oa, ob, loe_n, traffic, mosi;
  logic [2:0] bstr, od;
  logic [11:0] mult;
  logic [5:0] rdv;
  logic [15:0] refd, gpoe;
  logic [1:0] src;
  logic [12:0] otpa;
  logic [7:0] bbyte;
  logic [31:0] rdata;
  int num_errors = 0;
  int check_count = 0;

  always #5 i_clk = ~i_clk;

  cspbs_boot_ctrl #(.GPIO_W(16), .EXT_OSC_KHZ(EXT_KHZ), .RESET_DELAY(RD)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_osc_ext_n(osc_n), .i_pll_ratio_strap_lo(rlo),
    .i_pll_ratio_strap_hi(rhi), .i_boot_src_strap(bstr), .i_security_reg(sec),
    .i_boot_link_in_a(la), .i_boot_link_in_b(lb), .i_spi_miso(miso), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .o_osc_sel_ext(sel_ext), .o_analog_clk_sel_ext(), .o_pll_clk_en(pll_en),
    .o_output_divider(od), .o_pll_mult(mult), .o_ref_divider(rdv), .o_ref_clk_div(refd),
    .o_gpio_oe_n(gpoe), .o_gpio_pull_en(pull_en), .o_boot_start(bstart), .o_boot_src(src),
    .o_bootrom_bypass(bypass), .o_otp_start_addr(otpa), .o_spi_sclk(sclk), .o_spi_cs_n(cs_n),
    .o_spi_mosi(mosi), .o_spi_oe_n(spi_oe_n), .o_boot_byte(bbyte), .o_boot_byte_valid(bvalid),
    .o_link_pd_en(pd_en), .o_boot_link_out_a(oa), .o_boot_link_out_b(ob),
    .o_boot_link_oe_n(loe_n), .o_link_traffic(traffic));

  cspbs_board_model #(.FLASH_BYTE(FB)) board (.i_clk(i_clk), .i_rst(i_rst), .i_cfg_osc_n(cosc),
    .i_cfg_ratio(cratio), .i_cfg_boot(cboot), .i_link_talk(talk), .i_spi_sclk(sclk),
    .i_spi_cs_n(cs_n), .o_osc_ext_n(osc_n), .o_ratio_lo(rlo), .o_ratio_hi(rhi), .o_boot(bstr),
    .o_spi_miso(miso), .o_link_in_a(la), .o_link_in_b(lb));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge i_clk);
      #1 n++;
    end
    if (n >= lim) chk(32'h1, 32'h0);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic boot(input logic o, input logic [1:0] r, input logic [2:0] b, input logic [7:0] s);
    int n;
    @(posedge i_clk);
    i_rst <= 1'b1;
    cosc <= o;
    cratio <= r;
    cboot <= b;
    sec <= s;
    repeat (5) @(posedge i_clk);
    #1 chk({pull_en, pll_en, gpoe}, {2'b00, 16'hFFFF});
    @(posedge i_clk);
    i_rst <= 1'b0;
    wait_lvl(pull_en, 1'b1, RD + 5, n);
    chk(32'(n > RD - 3 && n < RD + 2), 32'h1);
    chk(bstart, 1'b1);
  endtask

  task automatic core_chk(input int osc, input logic [2:0] o, input logic [11:0] f, input logic [5:0] r);
    longint num;
    longint den;
    num = longint'(osc) * (f + 1);
    den = 2 * (r + 1) * (o + 1);
    repeat (100) @(posedge i_clk);
    reg_rd(ADDR_CORE_KHZ, 32'(num / den));
    chk(refd, 16'((num / den >= 100000) ? num / den / 100000 : 1));
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic sc_straps();
    logic [2:0] t_od [4] = '{3'h1, 3'h2, 3'h2, 3'h2};
    logic [11:0] t_f [4] = '{12'h07A, 12'h017, 12'h031, 12'h077};
    for (int c = 0; c < 4; c++) begin
      boot(1'b1, 2'(c), 3'h0, 8'h00);
      chk({sel_ext, od, mult, rdv}, {1'b0, t_od[c], t_f[c], 6'h00});
      core_chk(INT_OSC_KHZ, t_od[c], t_f[c], 6'h00);
      chk(src, 2'h0);
    end
    boot(1'b0, 2'h2, 3'h0, 8'h00);
    chk({sel_ext, od, mult}, {1'b1, 3'h2, 12'h031});
    core_chk(EXT_KHZ, 3'h2, 12'h031, 6'h00);
  endtask

  task automatic sc_regs();
    boot(1'b1, 2'h3, 3'h0, 8'h00);
    reg_rd(ADDR_PLL_CFG, 32'h0020_0077);
    reg_wr(ADDR_PLL_CFG, 32'h0000_1063);
    reg_rd(ADDR_PLL_CFG, 32'h0000_1063);
    chk({od, mult, rdv}, {3'h0, 12'h063, 6'h01});
    core_chk(INT_OSC_KHZ, 3'h0, 12'h063, 6'h01);
    reg_rd(ADDR_STATUS, 32'h0000_0609);
    reg_wr(8'h40, 32'hFFFF_FFFF);
    reg_rd(8'h40, 32'h0);
    reg_rd(ADDR_PLL_CFG, 32'h0000_1063);
  endtask

  task automatic sc_spi();
    int n;
    logic [7:0] cmd;
    boot(1'b1, 2'h3, BOOT_CODE_SPI, 8'h00);
    wait_lvl(spi_oe_n, 1'b0, 50, n);
    chk({src, cs_n}, {2'h1, 1'b0});
    for (int i = 0; i < 8; i++) begin
      wait_lvl(sclk, 1'b1, 100, n);
      cmd = {cmd[6:0], mosi};
      if (i == 1) chk(32'(n), 32'd20);
      wait_lvl(sclk, 1'b0, 100, n);
    end
    chk(cmd, SPI_READ_CMD);
    wait_lvl(bvalid, 1'b1, 2000, n);
    chk(bbyte, FB);
  endtask

  task automatic sc_link();
    int n;
    boot(1'b1, 2'h3, BOOT_CODE_LINK, 8'h00);
    wait_lvl(loe_n, 1'b0, 60, n);
    chk(32'(n > 10 && n < 30), 32'h1);
    chk({src, pd_en, oa, ob, traffic}, {2'h2, 4'h0});
    @(posedge i_clk);
    talk <= 1'b1;
    wait_lvl(traffic, 1'b1, 20, n);
    chk(traffic, 1'b1);
    @(posedge i_clk);
    talk <= 1'b0;
  endtask

  task automatic sc_otp();
    boot(1'b1, 2'h3, BOOT_CODE_LINK, 8'h20);
    repeat (3) @(posedge i_clk);
    #1 chk({src, bypass, otpa, spi_oe_n, loe_n}, {2'h3, 1'b1, 13'h0, 2'b11});
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    sc_straps();
    sc_regs();
    sc_spi();
    sc_link();
    sc_otp();
    final_report();
  end

  initial begin
    #200000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule // cspbs_boot_ctrl_test
`default_nettype wire

// File: cspbs_div_if.sv
// Purpose: Carrier between the boot controller and its divider
// Assumes: Single clock domain
// Notes: Start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
interface cspbs_div_if;
  logic start;
  logic [31:0] num;
  logic [31:0] den;
  logic busy;
  logic done;
  logic [31:0] quo;
  modport req (output start, output num, output den, input busy, input done, input quo);
  modport srv (input start, input num, input den, output busy, output done, output quo);
endinterface
`default_nettype wire

// File: cspbs_divider.sv
// Purpose: Sequential unsigned divider, one quotient bit per cycle
// Assumes: Denominator nonzero
// Notes: Starts ignored while busy
`timescale 1ns/100ps
`default_nettype none
module cspbs_divider
  import cspbs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  cspbs_div_if.srv div
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [32:0] rem;
    logic [31:0] num;
    logic [31:0] den;
    logic [31:0] quo;
  } cspbs_div_s;

  cspbs_div_s q;
  cspbs_div_s next_q;
  logic [32:0] trial;

  // ---------------------------------------------------------------
  // Restoring division
  // ---------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    trial = {q.rem[31:0], q.num[31]};
    if (!q.busy) begin
      if (div.start) begin
        next_q.busy = 1'b1;
        next_q.cnt = 6'h00;
        next_q.rem = 33'h0;
        next_q.num = div.num;
        next_q.den = div.den;
      end
    end else begin
      next_q.num = {q.num[30:0], 1'b0};
      if (trial >= {1'b0, q.den}) begin
        next_q.rem = trial - {1'b0, q.den};
        next_q.quo = {q.quo[30:0], 1'b1};
      end else begin
        next_q.rem = trial;
        next_q.quo = {q.quo[30:0], 1'b0};
      end
      next_q.cnt = q.cnt + 6'h01;
      if (q.cnt == 6'h1F) begin
        next_q.busy = 1'b0;
        next_q.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign div.busy = q.busy;
  assign div.done = q.done;
  assign div.quo = q.quo;

endmodule // cspbs_divider
`default_nettype wire

// File: cspbs_pkg.sv
// Purpose: Shared constants and types for the clock select and boot strap block
// Assumes: 100 MHz system clock
// Notes: Boot strap code mapping is held here so it can be changed in one place
package cspbs_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ = 100000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int INT_OSC_KHZ = 20000;
  localparam int REF_CLK_KHZ = 100000;
  localparam int SPI_SCLK_KHZ = 2500;
  localparam int SPI_HALF_CYC = CLK_KHZ / (2 * SPI_SCLK_KHZ);
  localparam int LINK_EN_NS = 200;
  localparam int LINK_EN_CYC = LINK_EN_NS / CLK_PERIOD_NS;
  localparam int RESET_DELAY_CLKS = 750000;
  localparam int STRAP_EDGE = 3;

  // ---------------------------------------------------------------
  // Synchroniser bit positions
  // ---------------------------------------------------------------
  localparam int PIN_W = 9;
  localparam int IDX_OSC = 0;
  localparam int IDX_RATIO_LO = 1;
  localparam int IDX_RATIO_HI = 2;
  localparam int IDX_BOOT = 3;
  localparam int IDX_LINK_A = 6;
  localparam int IDX_LINK_B = 7;
  localparam int IDX_MISO = 8;
  localparam int SEC_BOOT_BIT = 5;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PLL_CFG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CORE_KHZ = 8'h08;
  localparam logic [7:0] ADDR_REF_DIV = 8'h0C;
  localparam int F_LSB = 0;
  localparam int R_LSB = 12;
  localparam int OD_LSB = 20;

  // ---------------------------------------------------------------
  // Boot source strap codes
  // ---------------------------------------------------------------
  localparam logic [2:0] BOOT_CODE_SPI = 3'h3;
  localparam logic [2:0] BOOT_CODE_LINK = 3'h5;
  localparam logic [7:0] SPI_READ_CMD = 8'h03;

  typedef enum logic [1:0] {boot_none, boot_spi, boot_link, boot_otp} cspbs_boot_e;

  typedef struct packed {
    logic [2:0] od;
    logic [11:0] f;
    logic [5:0] r;
  } cspbs_pll_s;

  // Default PLL settings per ratio strap code {hi,lo}
  function automatic cspbs_pll_s pll_default(input logic [1:0] code);
    cspbs_pll_s p;
    p.r = 6'h00;
    unique case (code)
      2'b00: begin p.od = 3'h1; p.f = 12'd122; end
      2'b11: begin p.od = 3'h2; p.f = 12'd119; end
      2'b10: begin p.od = 3'h2; p.f = 12'd49; end
      2'b01: begin p.od = 3'h2; p.f = 12'd23; end
    endcase
    return p;
  endfunction

endpackage
